// File: logic/pccard_defs.svh
`ifndef PCCARD_DEFS_SVH
`define PCCARD_DEFS_SVH
// Space codes carried on the link
`define SPC_COMMON      2'h0
`define SPC_ATTRIB      2'h1
`define SPC_IO          2'h2
// Null value for undecodable common-memory reads
`define NULL_DATA       8'hFF
// Attribute memory layout (byte addresses, valid data at even bytes)
`define ATTR_CFG_BASE   8'hF8
`define ATTR_COR_ADDR   8'hF8
// Indirect window: common-memory offsets (even bytes)
`define IND_ADDR_LO     4'h0
`define IND_ADDR_HI     4'h2
`define IND_DATA        4'h4
`define IND_CTRL        4'h6
// IO map
`define IO_EXT_BIT      3
`define PAGE_BIT        0
`define CFG_LOC_BIT     7
// Local configuration register offsets (normal/local-bus numbering)
`define CFG_ROM_CTRL    4'h8
`define CFG_MIO_CFG     4'h9
`define CFG_DIVIDER     4'hA
`define CFG_MODE_STAT   4'hB
`define CFG_INT_STAT    4'hC
`define CFG_SOFT_RST    4'hD
`define CFG_GEN_CTRL    4'hE
`define CFG_PAGE_OUT    4'hF
// Reset values
`define CFG_RESET_VAL   8'h00
`define COR_RESET_VAL   8'h00
// Host APB register offsets
`define HREG_CMD        12'h000
`define HREG_ADDR       12'h004
`define HREG_WDATA      12'h008
`define HREG_RDATA      12'h00C
`define HREG_STATUS     12'h010
`endif

// File: logic/pccard_pkg.sv
package pccard_pkg;
    // Host cycle spaces
    typedef enum logic [1:0] {
        space_common = 2'b00,
        space_attrib = 2'b01,
        space_io     = 2'b10,
        space_none   = 2'b11
    } space_t;
    // Operating modes fixed by straps
    typedef enum logic [1:0] {
        mode_normal  = 2'b00,
        mode_generic = 2'b01,
        mode_local   = 2'b10
    } op_mode_t;
    // Decoded target of an IO cycle
    typedef enum logic [2:0] {
        tgt_uart  = 3'b000,
        tgt_ext   = 3'b001,
        tgt_cfg   = 3'b010,
        tgt_none  = 3'b011
    } io_target_t;
endpackage : pccard_pkg

// File: logic/pccard_if.sv
`timescale 1ns/1ps
interface pccard_if;
    logic       cyc_req;     // Host holds a cycle request
    logic [1:0] cyc_space;   // Space code
    logic       cyc_write;   // 1 for write
    logic [7:0] cyc_addr;    // Byte address
    logic [7:0] cyc_wdata;   // Write data
    logic       cyc_ack;     // Device completion pulse
    logic [7:0] cyc_rdata;   // Read data valid with ack
    modport device (input cyc_req, cyc_space, cyc_write, cyc_addr, cyc_wdata, output cyc_ack, cyc_rdata);
    modport host   (output cyc_req, cyc_space, cyc_write, cyc_addr, cyc_wdata, input cyc_ack, cyc_rdata);
endinterface : pccard_if

// File: logic/pc_card_target_decoder.sv
`timescale 1ns/1ps
`include "pccard_defs.svh"
// Overview of operation
// - Local-bus common memory is only indirect window
// - Invalid common-memory reads return 0xFF
// - Normal mode common-memory reads return 0xFF
// - Attribute memory always served, even bytes
// - Local-bus attribute memory advertises indirect access
// - Indirect cycles reach CIS and config registers
// - IO cycles carry 8-bit data only
// - IO writes complete at once, UART/external reads one cycle later
// - IO functions enabled only after COR set
// - IO offsets 0-7 map to UART registers
// - Local-bus mode forwards 8-F to external bus
// - Paging bit clear selects external bus
// - A3 selects internal versus external target
// - Normal mode config registers always at 8-F
// - Local-bus config registers need paging bit
// - Generic paging overlays config on 0-7
// - Eight config registers in fixed order
// - Driver pages in via 0xFE then 0x01
// - Offset 7 bit 7 reports config location
// - Outside generic mode, driver pages out via 0xFE then 0x00
// - Serial ROM loads use offsets 8-F
// - Mode strap low normal, high local bus
// - Generic mode decodes three IO address bits
module pc_card_target_decoder
    import pccard_pkg::*;
(
    input  wire logic       pclk,          // System clock
    input  wire logic       presetn,       // Async reset, active low
    input  wire logic       clk_en,        // Freezes all state when low
    pccard_if.device        card,          // Host-facing cycle port
    input  wire logic       mode_strap,    // Mode pin, low normal
    input  wire logic       generic_strap, // Generic decode select
    input  wire logic       rom_load,      // Serial ROM load strobe
    input  wire logic [3:0] rom_addr,      // Serial ROM load offset
    input  wire logic [7:0] rom_data,      // Serial ROM load data
    output logic            uart_sel,      // UART access pulse
    output logic            uart_wr,       // UART write
    output logic [2:0]      uart_addr,     // UART register index
    output logic [7:0]      uart_wdata,    // UART write data
    input  wire logic [7:0] uart_rdata,    // UART read data
    output logic            ext_sel,       // External bus access pulse
    output logic            ext_wr,        // External bus write
    output logic [2:0]      ext_addr,      // External bus address
    output logic [7:0]      ext_wdata,     // External bus write data
    input  wire logic [7:0] ext_rdata,     // External bus read data
    output logic            io_enabled,    // Configuration options set
    output logic            page_bit       // Paging bit mirror
);
    import pccard_pkg::*;

    // Strap synchronisers and captured mode
    logic [1:0] mode_sync, gen_sync;       // Two-stage synchronisers
    logic [1:0] next_mode_sync, next_gen_sync;
    op_mode_t   mode, next_mode;           // Mode caught after release
    logic       mode_valid, next_mode_valid;
    logic [1:0] settle, next_settle;       // Marks synchroniser fill
    // Device state
    logic [7:0] cfg_regs [0:7];            // Local configuration registers
    logic [7:0] next_cfg [0:7];
    logic [7:0] cor, next_cor;             // Configuration options register
    logic [7:0] scratch_index_reg, next_scratch;   // Index pointer shadow
    logic [7:0] mode_select_reg, next_msel;        // Paging shadow
    logic [15:0] ind_addr, next_ind_addr;  // Indirect attribute pointer
    logic       ack, next_ack;
    logic [7:0] rdata, next_rdata;
    logic       usel, next_usel, esel, next_esel, xwr, next_xwr;
    logic [2:0] xaddr, next_xaddr;
    logic [7:0] xwdata, next_xwdata;
    logic       pend, next_pend;           // Outstanding UART/external read
    io_target_t pend_tgt, next_pend_tgt;

    // CIS bytes plus config register space in attribute memory
    function automatic logic [7:0] attr_read(input logic [7:0] a, input op_mode_t m, input logic [7:0] c);
        logic [7:0] v;
        v = 8'h00;
        if (a[0])
            v = `NULL_DATA;
        else if (a == `ATTR_COR_ADDR)
            v = c;
        else if (a >= `ATTR_CFG_BASE)
            v = 8'h00;
        else if (a == 8'h00)
            v = (m == mode_local) ? 8'h01 : 8'h00;
        else if (a == 8'h02)
            v = (m == mode_generic) ? 8'h08 : 8'h10;
        else
            v = `NULL_DATA;
        return v;
    endfunction : attr_read

    // IO target decode
    function automatic io_target_t io_decode(input logic [7:0] a, input op_mode_t m, input logic pg,
                                             input logic en);
        io_target_t t;
        t = tgt_none;
        if (!en)
            t = tgt_none;
        else if (m == mode_generic)
            t = pg ? tgt_cfg : tgt_uart;
        else if (!a[`IO_EXT_BIT])
            t = tgt_uart;
        else if (m == mode_normal)
            t = tgt_cfg;
        else
            t = pg ? tgt_cfg : tgt_ext;
        return t;
    endfunction : io_decode

    // Strap capture: combinational next state
    always_comb
    begin
        next_mode_sync  = {mode_sync[0], mode_strap};
        next_gen_sync   = {gen_sync[0], generic_strap};
        next_settle     = {settle[0], 1'b1};
        next_mode_valid = mode_valid | settle[1];
        next_mode       = mode;
        if (!mode_valid && settle[1])
        begin
            // Strap decides once, after synchronisers settle
            if (mode_sync[1])
                next_mode = mode_local;
            else if (gen_sync[1])
                next_mode = mode_generic;
            else
                next_mode = mode_normal;
        end
    end

    // Strap capture registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_sync  <= 2'b00;
            gen_sync   <= 2'b00;
            mode       <= mode_normal;
            mode_valid <= 1'b0;
            settle     <= 2'b00;
        end
        else if (clk_en)
        begin
            mode_sync  <= next_mode_sync;
            gen_sync   <= next_gen_sync;
            mode       <= next_mode;
            mode_valid <= next_mode_valid;
            settle     <= next_settle;
        end
    end

    // Cycle handling: combinational next state
    always_comb
    begin
        io_target_t t;
        logic [7:0] a;
        t = tgt_none;
        a = card.cyc_addr;
        for (int i = 0; i < 8; i++)
            next_cfg[i] = cfg_regs[i];
        next_cor      = cor;
        next_scratch  = scratch_index_reg;
        next_msel     = mode_select_reg;
        next_ind_addr = ind_addr;
        next_ack      = 1'b0;
        next_rdata    = rdata;
        next_usel     = 1'b0;
        next_esel     = 1'b0;
        next_xwr      = xwr;
        next_xaddr    = xaddr;
        next_xwdata   = xwdata;
        next_pend     = 1'b0;
        next_pend_tgt = pend_tgt;
        // Serial ROM load always uses 8-F numbering
        if (rom_load && rom_addr[3])
            next_cfg[rom_addr[2:0]] = rom_data;
        if (pend)
        begin
            // Read data from UART or external bus arrives one cycle later
            next_ack   = 1'b1;
            next_rdata = (pend_tgt == tgt_ext) ? ext_rdata : uart_rdata;
        end
        else if (card.cyc_req && !ack && mode_valid)
        begin
            next_ack = 1'b1;
            case (space_t'(card.cyc_space))
                space_attrib:
                begin
                    if (card.cyc_write && a == `ATTR_COR_ADDR)
                        next_cor = card.cyc_wdata;
                    next_rdata = attr_read(a, mode, cor);
                end
                space_common:
                begin
                    next_rdata = `NULL_DATA;
                    if (mode == mode_local && !a[0] && a[7:4] == 4'h0)
                    begin
                        // Indirect window onto attribute memory
                        case (a[3:0])
                            `IND_ADDR_LO:
                            begin
                                if (card.cyc_write) next_ind_addr[7:0] = card.cyc_wdata;
                                next_rdata = ind_addr[7:0];
                            end
                            `IND_ADDR_HI:
                            begin
                                if (card.cyc_write) next_ind_addr[15:8] = card.cyc_wdata;
                                next_rdata = ind_addr[15:8];
                            end
                            `IND_DATA:
                            begin
                                if (card.cyc_write && ind_addr[7:0] == `ATTR_COR_ADDR)
                                    next_cor = card.cyc_wdata;
                                next_rdata = attr_read(ind_addr[7:0], mode, cor);
                            end
                            default: next_rdata = `NULL_DATA;
                        endcase
                    end
                end
                space_io:
                begin
                    t = io_decode(a, mode, mode_select_reg[`PAGE_BIT], io_enabled);
                    next_xwr    = card.cyc_write;
                    next_xaddr  = a[2:0];
                    next_xwdata = card.cyc_wdata;
                    next_rdata  = `NULL_DATA;
                    case (t)
                        tgt_uart, tgt_ext:
                        begin
                            next_usel = (t == tgt_uart);
                            next_esel = (t == tgt_ext);
                            if (t == tgt_uart && card.cyc_write)
                            begin
                                // Shadow index and paging writes
                                if (a[2:0] == 3'h7)
                                    next_scratch = card.cyc_wdata;
                                if (a[2:0] == 3'h5 && scratch_index_reg == 8'hFE)
                                    next_msel = card.cyc_wdata;
                            end
                            if (!card.cyc_write)
                            begin
                                next_ack      = 1'b0;
                                next_pend     = 1'b1;
                                next_pend_tgt = t;
                            end
                        end
                        tgt_cfg:
                        begin
                            if (card.cyc_write)
                                next_cfg[a[2:0]] = card.cyc_wdata;
                            next_rdata = cfg_regs[a[2:0]];
                            // Offset 7 bit 7 tells the driver where the bank sits
                            if (a[2:0] == 3'h7)
                                next_rdata[`CFG_LOC_BIT] = (mode != mode_generic);
                        end
                        default: next_rdata = `NULL_DATA;
                    endcase
                end
                default: next_rdata = `NULL_DATA;
            endcase
        end
    end

    // Cycle handling registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 8; i++)
                cfg_regs[i] <= `CFG_RESET_VAL;
            cor               <= `COR_RESET_VAL;
            scratch_index_reg <= 8'h00;
            mode_select_reg   <= 8'h00;
            ind_addr          <= 16'h0000;
            ack               <= 1'b0;
            rdata             <= 8'h00;
            usel              <= 1'b0;
            esel              <= 1'b0;
            xwr               <= 1'b0;
            xaddr             <= 3'h0;
            xwdata            <= 8'h00;
            pend              <= 1'b0;
            pend_tgt          <= tgt_none;
            io_enabled        <= 1'b0;
        end
        else if (clk_en)
        begin
            for (int i = 0; i < 8; i++)
                cfg_regs[i] <= next_cfg[i];
            cor               <= next_cor;
            scratch_index_reg <= next_scratch;
            mode_select_reg   <= next_msel;
            ind_addr          <= next_ind_addr;
            ack               <= next_ack;
            rdata             <= next_rdata;
            usel              <= next_usel;
            esel              <= next_esel;
            xwr               <= next_xwr;
            xaddr             <= next_xaddr;
            xwdata            <= next_xwdata;
            pend              <= next_pend;
            pend_tgt          <= next_pend_tgt;
            io_enabled        <= (next_cor[5:0] != 6'h00);
        end
    end

    assign card.cyc_ack   = ack;
    assign card.cyc_rdata = rdata;
    assign uart_sel   = usel;
    assign uart_wr    = xwr;
    assign uart_addr  = xaddr;
    assign uart_wdata = xwdata;
    assign ext_sel    = esel;
    assign ext_wr     = xwr;
    assign ext_addr   = xaddr;
    assign ext_wdata  = xwdata;
    assign page_bit   = mode_select_reg[`PAGE_BIT];
endmodule : pc_card_target_decoder

// File: logic/pc_card_host_end.sv
`timescale 1ns/1ps
`include "pccard_defs.svh"
module pc_card_host_end
    import pccard_pkg::*;
(
    input  wire logic        pclk,     // System clock
    input  wire logic        presetn,  // Async reset, active low
    input  wire logic        clk_en,   // Freezes all state when low
    pccard_if.host           card,     // Link to the card
    input  wire logic        psel,     // APB select
    input  wire logic        penable,  // APB enable
    input  wire logic        pwrite,   // APB direction
    input  wire logic [11:0] paddr,    // APB address
    input  wire logic [31:0] pwdata,   // APB write data
    output logic [31:0]      prdata,   // APB read data
    output logic             pready,   // APB ready
    output logic             pslverr   // APB error
);
    import pccard_pkg::*;

    // Command: [1:0] space, [2] write; issued on write to CMD
    logic [7:0] addr_q, next_addr, wdata_q, next_wdata, rd_q, next_rd;
    logic [2:0] cmd_q, next_cmd;
    logic       busy, next_busy, done, next_done;
    logic       req, next_req;
    logic [31:0] prd, next_prd;
    logic       rdy, next_rdy, err, next_err;

    // Command engine and APB slave: next values
    always_comb
    begin
        next_addr = addr_q;
        next_wdata = wdata_q;
        next_rd = rd_q;
        next_cmd = cmd_q;
        next_busy = busy;
        next_done = done;
        next_req = req;
        next_prd = prd;
        next_rdy = 1'b0;
        next_err = 1'b0;
        // Link side: hold request until the card acknowledges
        if (req && card.cyc_ack)
        begin
            next_req  = 1'b0;
            next_busy = 1'b0;
            next_done = 1'b1;
            next_rd   = card.cyc_rdata;
        end
        // One wait state: answer in the second access cycle
        if (psel && penable && !rdy)
        begin
            next_rdy = 1'b1;
            next_prd = 32'h0000_0000;
            case (paddr)
                `HREG_CMD:
                begin
                    // Driver keeps order: COR first, then IO
                    if (pwrite && !busy)
                    begin
                        next_cmd  = pwdata[2:0];
                        next_req  = 1'b1;
                        next_busy = 1'b1;
                        next_done = 1'b0;
                    end
                    next_prd = {29'h0, cmd_q};
                end
                `HREG_ADDR:
                begin
                    if (pwrite) next_addr = pwdata[7:0];
                    next_prd = {24'h0, addr_q};
                end
                `HREG_WDATA:
                begin
                    if (pwrite) next_wdata = pwdata[7:0];
                    next_prd = {24'h0, wdata_q};
                end
                `HREG_RDATA: next_prd = {24'h0, rd_q};
                `HREG_STATUS: next_prd = {30'h0, done, busy};
                default: next_err = 1'b1;
            endcase
        end
    end

    // Host registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            addr_q <= 8'h00;
            wdata_q <= 8'h00;
            rd_q <= 8'h00;
            cmd_q <= 3'h0;
            busy <= 1'b0;
            done <= 1'b0;
            req <= 1'b0;
            prd <= 32'h0000_0000;
            rdy <= 1'b0;
            err <= 1'b0;
        end
        else if (clk_en)
        begin
            addr_q <= next_addr;
            wdata_q <= next_wdata;
            rd_q <= next_rd;
            cmd_q <= next_cmd;
            busy <= next_busy;
            done <= next_done;
            req <= next_req;
            prd <= next_prd;
            rdy <= next_rdy;
            err <= next_err;
        end
    end

    assign card.cyc_req   = req;
    assign card.cyc_space = cmd_q[1:0];
    assign card.cyc_write = cmd_q[2];
    assign card.cyc_addr  = addr_q;
    assign card.cyc_wdata = wdata_q;
    assign prdata  = prd;
    assign pready  = rdy;
    assign pslverr = err;
endmodule : pc_card_host_end

// File: dv/pc_card_link_chk.sv
`timescale 1ns/1ps
`include "pccard_defs.svh"
// Watches the card link between the two ends
module pc_card_link_chk (
    input wire logic       pclk,      // Clock
    input wire logic       presetn,   // Async reset, active low
    input wire logic       cyc_req,   // Host request level
    input wire logic [1:0] cyc_space, // Space code
    input wire logic       cyc_write, // Direction
    input wire logic [7:0] cyc_addr,  // Byte address
    input wire logic [7:0] cyc_wdata, // Write data
    input wire logic       cyc_ack,   // Device completion
    input wire logic [7:0] cyc_rdata  // Read data
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Handshake shape: ack is a pulse inside a held request
    a_ack_pulse: assert property (cyc_ack |=> !cyc_ack) else $error("ack longer than one cycle");
    a_ack_in_req: assert property (cyc_ack |-> cyc_req) else $error("ack without request");
    a_req_held: assert property (cyc_req && !cyc_ack |=> cyc_req) else $error("request dropped early");
    a_req_drop: assert property (cyc_ack |=> !cyc_req) else $error("request kept after ack");
    a_req_stable: assert property (cyc_req && !cyc_ack |=> $stable(cyc_addr) && $stable(cyc_space)
        && $stable(cyc_write) && $stable(cyc_wdata)) else $error("request changed while pending");
    // IO cycles must be acknowledged within three cycles of the request
    a_io_fast: assert property ($rose(cyc_req) && cyc_space == `SPC_IO |-> ##[1:3] cyc_ack)
        else $error("io cycle too slow");
    a_common_null: assert property (cyc_ack && cyc_space == `SPC_COMMON && !cyc_write
        && !(cyc_addr inside {8'h00, 8'h02, 8'h04}) |-> cyc_rdata == `NULL_DATA)
        else $error("common read not null");
    a_attr_odd: assert property (cyc_ack && cyc_space == `SPC_ATTRIB && !cyc_write && cyc_addr[0]
        |-> cyc_rdata == 8'hFF) else $error("odd attribute byte not null");
    c_io_wr: cover property (cyc_ack && cyc_space == `SPC_IO && cyc_write);
    c_io_rd: cover property (cyc_ack && cyc_space == `SPC_IO && !cyc_write);
    c_attr: cover property (cyc_ack && cyc_space == `SPC_ATTRIB);
endmodule : pc_card_link_chk

// File: dv/tb_top.sv
`timescale 1ns/1ps
`include "pccard_defs.svh"
module tb_top;
    import pccard_pkg::*;
    logic        pclk, presetn, mode_strap, generic_strap, rom_load;  // Clock, reset, straps
    logic [3:0]  rom_addr;                                           // Serial ROM offset
    logic [7:0]  rom_data, uart_rdata, ext_rdata;                    // Load data, target models
    logic        psel, penable, pwrite, pready, pslverr, serr;       // APB
    logic [11:0] paddr;                                              // APB address
    logic [31:0] pwdata, prdata, rd;                                 // APB data
    logic        uart_sel, uart_wr, ext_sel, ext_wr, io_enabled, page_bit; // Device side
    logic [2:0]  uart_addr, ext_addr;                                // Target indices
    logic [7:0]  uart_wdata, ext_wdata;                              // Target write data
    logic [31:0] rows [15];                                          // space,write,addr,wdata,expect
    int          n_errors, num_checks;                               // Counters
    pccard_if card ();
    // Target models answer from the registered index so a wrong route shows
    assign uart_rdata = 8'hA0 | {5'h0, uart_addr};
    assign ext_rdata  = 8'h50 | {5'h0, ext_addr};
    pc_card_target_decoder u_pc_card_target_decoder (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
        .card(card.device), .mode_strap(mode_strap), .generic_strap(generic_strap), .rom_load(rom_load),
        .rom_addr(rom_addr), .rom_data(rom_data), .uart_sel(uart_sel), .uart_wr(uart_wr),
        .uart_addr(uart_addr), .uart_wdata(uart_wdata), .uart_rdata(uart_rdata), .ext_sel(ext_sel),
        .ext_wr(ext_wr), .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata),
        .io_enabled(io_enabled), .page_bit(page_bit));
    pc_card_host_end u_pc_card_host_end (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .card(card.host),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    pc_card_link_chk u_pc_card_link_chk (.pclk(pclk), .presetn(presetn), .cyc_req(card.cyc_req),
        .cyc_space(card.cyc_space), .cyc_write(card.cyc_write), .cyc_addr(card.cyc_addr),
        .cyc_wdata(card.cyc_wdata), .cyc_ack(card.cyc_ack), .cyc_rdata(card.cyc_rdata));
    // Free running clock, 8 ns period
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // Verdict and end of run
    task results;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            n_errors++;
        end
    endtask : chk
    // One APB transfer; the request stands until pready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
        if (k >= 50)
        begin
            n_errors++;
            results();
        end
    endtask : apb
    // Whole card cycle: set up, launch, wait for idle, fetch read data
    task card_cyc(input logic [1:0] sp, input logic w, input logic [7:0] a, input logic [7:0] d);
        int k;
        apb(1'b1, `HREG_ADDR, {24'h0, a});
        apb(1'b1, `HREG_WDATA, {24'h0, d});
        apb(1'b1, `HREG_CMD, {29'h0, w, sp});
        k = 0;
        do
        begin
            apb(1'b0, `HREG_STATUS, 32'h0);
            k++;
        end
        while (rd[0] !== 1'b0 && k < 20);
        if (k >= 20)
        begin
            n_errors++;
            results();
        end
        apb(1'b0, `HREG_RDATA, 32'h0);
    endtask : card_cyc
    // Straps are latched after reset, so each mode gets a fresh reset
    task do_reset(input logic m, input logic g);
        presetn <= 1'b0; mode_strap <= m; generic_strap <= g;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
    endtask : do_reset
    initial
    begin
        presetn = 1'b0; mode_strap = 1'b1; generic_strap = 1'b0; rom_load = 1'b0; rom_addr = 4'h0;
        rom_data = 8'h00; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0;
        n_errors = 0; num_checks = 0;
        rows = '{32'h0008_00FF, 32'h1000_0001, 32'h1002_0010, 32'h1001_00FF, 32'h11F8_0100,
                 32'h2003_00A3, 32'h2009_0051, 32'h2107_FE00, 32'h2105_0100, 32'h200F_0080,
                 32'h2109_0300, 32'h2009_0003, 32'h2107_FE00, 32'h2105_0000, 32'h2009_0051};
        do_reset(1'b1, 1'b0);
        chk("io_enabled", 32'h0, {31'h0, io_enabled});
        for (int i = 0; i < 15; i++)
        begin
            card_cyc(rows[i][29:28], rows[i][24], rows[i][23:16], rows[i][15:8]);
            if (rows[i][24] === 1'b0)
                chk("row read", {24'h0, rows[i][7:0]}, rd);
        end
        chk("page_bit", 32'h0, {31'h0, page_bit});
        apb(1'b0, 12'h020, 32'h0);
        chk("pslverr", 32'h1, {31'h0, serr});
        do_reset(1'b0, 1'b0);
        card_cyc(`SPC_COMMON, 1'b0, 8'h00, 8'h00);
        chk("normal common", 32'hFF, rd);
        card_cyc(`SPC_ATTRIB, 1'b1, `ATTR_COR_ADDR, 8'h01);
        chk("io_enabled", 32'h1, {31'h0, io_enabled});
        card_cyc(`SPC_IO, 1'b0, 8'h09, 8'h00);
        chk("normal cfg", 32'h00, rd);
        rom_load <= 1'b1; rom_addr <= 4'h9; rom_data <= 8'h02;
        @(posedge pclk);
        rom_load <= 1'b0;
        card_cyc(`SPC_IO, 1'b0, 8'h09, 8'h00);
        chk("rom load", 32'h02, rd);
        card_cyc(`SPC_ATTRIB, 1'b1, `ATTR_COR_ADDR, 8'h00);
        card_cyc(`SPC_IO, 1'b1, 8'h09, 8'h55);
        card_cyc(`SPC_ATTRIB, 1'b1, `ATTR_COR_ADDR, 8'h01);
        card_cyc(`SPC_IO, 1'b0, 8'h09, 8'h00);
        chk("ignored write", 32'h02, rd);
        do_reset(1'b0, 1'b1);
        card_cyc(`SPC_ATTRIB, 1'b0, 8'h02, 8'h00);
        chk("generic range", 32'h08, rd);
        card_cyc(`SPC_ATTRIB, 1'b1, `ATTR_COR_ADDR, 8'h01);
        card_cyc(`SPC_IO, 1'b1, 8'h07, 8'hFE);
        card_cyc(`SPC_IO, 1'b1, 8'h05, 8'h01);
        chk("page_bit", 32'h1, {31'h0, page_bit});
        chk("uart_bus", 32'h0000_0D01, {20'h0, uart_wr, uart_addr, uart_wdata});
        card_cyc(`SPC_IO, 1'b0, 8'h07, 8'h00);
        chk("generic loc", 32'h0, {31'h0, rd[7]});
        results();
    end
endmodule : tb_top
